// >>> hdl/schs_pkg.sv
// Package with constants and types for the serial channel host-service block.
package schs_pkg;

  // Register offsets on the plain register port.
  localparam logic [3:0] OFS_ICR       = 4'h0;
  localparam logic [3:0] OFS_IVR       = 4'h1;
  localparam logic [3:0] OFS_MODIFIED_VECTOR_REG      = 4'h2;
  localparam logic [3:0] OFS_GSR       = 4'h3;
  localparam logic [3:0] OFS_PORT_CONTROL_REG_A      = 4'h4;
  localparam logic [3:0] OFS_IER_A     = 4'h5;
  localparam logic [3:0] OFS_IER_B     = 4'h6;
  localparam logic [3:0] OFS_COUNTER_CONTROL_REG_A    = 4'h7;
  localparam logic [3:0] OFS_COUNTER_CONTROL_REG_B    = 4'h8;
  localparam logic [3:0] OFS_OMR_A     = 4'h9;
  localparam logic [3:0] OFS_OMR_B     = 4'ha;
  localparam logic [3:0] OFS_CHANNEL_MODE_REG_2_A    = 4'hb;
  localparam logic [3:0] OFS_CHANNEL_MODE_REG_2_B    = 4'hc;
  localparam logic [3:0] OFS_TPR_A     = 4'hd;
  localparam logic [3:0] OFS_TPR_B     = 4'he;

  // Field positions.
  localparam int ICR_MIE_A      = 1;
  localparam int ICR_MIE_B      = 0;
  localparam int ICR_VMOD       = 2;
  localparam int ICR_VPOS       = 3;
  localparam int ICR_VEC_LO     = 4;
  localparam int ICR_VEC_HI     = 5;
  localparam int ICR_PRI_LO     = 6;
  localparam int ICR_PRI_HI     = 7;
  localparam int COUNTER_CONTROL_REG_ZC_IE     = 7;
  localparam int PORT_CONTROL_REG_A_CHAIN     = 7;
  localparam int OMR_RX_FULL    = 3;
  localparam int OMR_TX_EMPTY   = 4;
  localparam int TPR_AUTO_EOM   = 4;
  localparam int CHANNEL_MODE_REG_2_DMA_LO    = 3;
  localparam int CHANNEL_MODE_REG_2_DMA_HI    = 5;
  localparam int RSR_EOM        = 7;
  // Interrupt enable register bit for each condition group.
  localparam int IER_EXT        = 0;
  localparam int IER_ERR        = 1;
  localparam int IER_TXR        = 2;
  localparam int IER_RXR        = 3;
  localparam int FIFO_DEPTH     = 4;

  // Reset values.
  localparam logic [7:0] RST_REG = 8'h00;

  // DMA mode encodings of the channel mode field.
  localparam logic [2:0] DMA_NONE = 3'h0;
  localparam logic [2:0] DMA_HSA  = 3'h1;
  localparam logic [2:0] DMA_HDA  = 3'h2;
  localparam logic [2:0] DMA_FSA  = 3'h3;
  localparam logic [2:0] DMA_FDA  = 3'h4;
  localparam logic [2:0] DMA_WAIT = 3'h5;

  // Per-channel status coming from the channel engines.
  typedef struct packed {
    logic [7:0] input_counter_status;
    logic [7:0] receiver_status;
    logic [7:0] tx_rx_status;
    logic [2:0] rx_count;
    logic [2:0] tx_count;
    logic       tx_enabled;
    logic       tc_reached;
    logic       head_eom;
  } schs_chan_stat_t;

  typedef enum logic [2:0] {
    ACK_IDLE  = 3'b001,
    ACK_OWN   = 3'b010,
    ACK_CHAIN = 3'b100
  } schs_ack_state_t;

endpackage : schs_pkg

// >>> hdl/schs_host_service.sv
// Host-service logic: interrupt merge, vectored acknowledge, DMA handshakes.
`timescale 1ns/1ps
`default_nettype none

module schs_host_service
  import schs_pkg::*;
(
  input  wire logic            clock,
  input  wire logic            reset,
  input  wire logic [3:0]      reg_addr,
  input  wire logic [7:0]      reg_wdata,
  input  wire logic            reg_write,
  input  wire logic            reg_read,
  output logic [7:0]           reg_rdata,
  input  wire schs_chan_stat_t chan_stat_a,
  input  wire schs_chan_stat_t chan_stat_b,
  input  wire logic            interrupt_ack_in_n,
  output logic                 interrupt_request_out_n,
  output logic                 transfer_ack_out_n,
  output logic [7:0]           vector_out,
  output logic                 vector_oe,
  output logic                 osc_or_ack_chain_out,
  output logic [1:0]           rx_or_shared_request_n,
  output logic [1:0]           tx_request_n,
  input  wire logic [1:0]      rx_or_shared_ack_n,
  input  wire logic [1:0]      tx_ack_n,
  input  wire logic            transfer_complete_in_n,
  input  wire logic            transfer_done_in_n,
  output logic                 transfer_done_n,
  output logic                 transfer_done_oe,
  input  wire logic            fifo_access,
  input  wire logic            fifo_write,
  input  wire logic            fifo_chan,
  output logic [1:0]           rx_pop,
  output logic [1:0]           tx_push,
  output logic [1:0]           frame_end_req
);

  logic [7:0] icr_r, ivr_r, port_control_reg_a_r;
  logic [7:0] ier_r [2];
  logic [7:0] counter_control_reg_r [2];
  logic [7:0] omr_r [2];
  logic [7:0] channel_mode_reg_2_r [2];
  logic [7:0] tpr_r [2];
  schs_chan_stat_t cs [2];
  assign cs[0] = chan_stat_a;
  assign cs[1] = chan_stat_b;

  // Pins from the bus pass two flip-flops before use.
  logic [6:0] sync1_r, sync2_r, sync_d_r;
  always_ff @(posedge clock) begin
    if (reset) begin
      sync1_r  <= 7'h7f;
      sync2_r  <= 7'h7f;
      sync_d_r <= 7'h7f;
    end else begin
      sync1_r  <= {transfer_done_in_n, transfer_complete_in_n, tx_ack_n,
                   rx_or_shared_ack_n, interrupt_ack_in_n};
      sync2_r  <= sync1_r;
      sync_d_r <= sync2_r;
    end
  end
  logic       iack_n, dtc_n, done_in_n;
  logic [1:0] rak_n, tak_n, rak_fall, tak_fall;
  assign iack_n    = sync2_r[0];
  assign rak_n     = sync2_r[2:1];
  assign tak_n     = sync2_r[4:3];
  assign dtc_n     = sync2_r[5];
  assign done_in_n = sync2_r[6];
  assign rak_fall  = sync_d_r[2:1] & ~rak_n;
  assign tak_fall  = sync_d_r[4:3] & ~tak_n;

  // Per-channel condition vectors: {receive_ready_cond, transmit_ready_cond, err, ext}.
  logic [3:0] cond [2];
  logic [3:0] act [2];
  logic [1:0] rx_rdy, tx_rdy;
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      rx_rdy[c] = omr_r[c][OMR_RX_FULL] ? (cs[c].rx_count == 3'(FIFO_DEPTH))
                                         : (cs[c].rx_count != 3'h0);
      tx_rdy[c] = cs[c].tx_enabled &&
                  (omr_r[c][OMR_TX_EMPTY] ? (cs[c].tx_count == 3'h0)
                                          : (cs[c].tx_count != 3'(FIFO_DEPTH)));
      cond[c][0] = cs[c].input_counter_status[4] | cs[c].input_counter_status[5] |
                   (cs[c].input_counter_status[6] & counter_control_reg_r[c][COUNTER_CONTROL_REG_ZC_IE]);
      cond[c][1] = (|cs[c].receiver_status) | (|cs[c].tx_rx_status[7:3]);
      cond[c][2] = tx_rdy[c];
      cond[c][3] = rx_rdy[c];
      act[c] = cond[c] & {ier_r[c][IER_RXR], ier_r[c][IER_TXR],
                          ier_r[c][IER_ERR], ier_r[c][IER_EXT]};
    end
  end

  // Status layout: channel A in bits 3:0, channel B in bits 7:4.
  logic [7:0] gsr_live, gsr_r;
  logic       frozen;
  assign gsr_live = {cond[1], cond[0]};

  logic [1:0] chan_on;
  assign chan_on = {act[1] != 4'h0 && icr_r[ICR_MIE_B],
                    act[0] != 4'h0 && icr_r[ICR_MIE_A]};

  // Fixed order within a channel: error, receive, transmit, external.
  function automatic logic [1:0] pick(input logic [3:0] a);
    if (a[1]) pick = 2'h0;
    else if (a[3]) pick = 2'h1;
    else if (a[2]) pick = 2'h2;
    else pick = 2'h3;
  endfunction : pick

  logic       win_ch;
  logic [2:0] code;
  always_comb begin
    // Priority bit 7 set favours channel B; bit 6 is kept for software use.
    if (icr_r[ICR_PRI_HI]) win_ch = chan_on[1] ? 1'b1 : 1'b0;
    else win_ch = chan_on[0] ? 1'b0 : 1'b1;
    code = {win_ch, win_ch ? pick(act[1]) : pick(act[0])};
  end

  logic [7:0] modified_vector_reg_live, modified_vector_reg_r;
  always_comb begin
    modified_vector_reg_live = ivr_r;
    if (icr_r[ICR_VMOD]) begin
      if (icr_r[ICR_VPOS]) modified_vector_reg_live[4:2] = code;
      else modified_vector_reg_live[2:0] = code;
    end
  end

  // Status and vector are frozen while an acknowledge is in progress.
  logic pend_r;
  always_ff @(posedge clock) begin
    if (reset) begin
      gsr_r  <= RST_REG;
      modified_vector_reg_r <= RST_REG;
      pend_r <= 1'b0;
    end else if (!frozen) begin
      gsr_r  <= gsr_live;
      modified_vector_reg_r <= modified_vector_reg_live;
      pend_r <= |chan_on;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) interrupt_request_out_n <= 1'b1;
    else interrupt_request_out_n <= ~pend_r;
  end

  // Acknowledge sequencer.
  schs_ack_state_t ack_r;
  logic            bus_ack;
  assign frozen = (ack_r != ACK_IDLE) || !iack_n;
  always_ff @(posedge clock) begin
    if (reset) begin
      ack_r                <= ACK_IDLE;
      vector_out           <= RST_REG;
      vector_oe            <= 1'b0;
      osc_or_ack_chain_out <= 1'b1;
    end else begin
      case (ack_r)
        ACK_IDLE: begin
          if (!iack_n) begin
            if (pend_r) begin
              ack_r      <= ACK_OWN;
              vector_oe  <= (icr_r[ICR_VEC_HI:ICR_VEC_LO] != 2'h0);
              vector_out <= icr_r[ICR_VMOD] ? modified_vector_reg_r : ivr_r;
            end else if (port_control_reg_a_r[PORT_CONTROL_REG_A_CHAIN]) begin
              ack_r                <= ACK_CHAIN;
              osc_or_ack_chain_out <= 1'b0;
            end
          end
        end
        ACK_OWN: begin
          if (iack_n) begin
            ack_r     <= ACK_IDLE;
            vector_oe <= 1'b0;
          end
        end
        ACK_CHAIN: begin
          if (iack_n) begin
            ack_r                <= ACK_IDLE;
            osc_or_ack_chain_out <= 1'b1;
          end
        end
        default: ack_r <= ACK_IDLE;
      endcase
    end
  end

  // DMA requests and single-address acknowledges.
  logic [2:0] mode [2];
  logic [1:0] rx_hold_r, tx_hold_r, shared_rx_r;
  logic [1:0] wait_ok;
  logic       wait_pend_r;
  always_comb begin
    for (int c = 0; c < 2; c++) mode[c] = channel_mode_reg_2_r[c][CHANNEL_MODE_REG_2_DMA_HI:CHANNEL_MODE_REG_2_DMA_LO];
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      rx_or_shared_request_n <= 2'h3;
      tx_request_n           <= 2'h3;
      rx_hold_r              <= 2'h0;
      tx_hold_r              <= 2'h0;
      shared_rx_r            <= 2'h0;
      rx_pop                 <= 2'h0;
      tx_push                <= 2'h0;
      transfer_done_n        <= 1'b1;
      transfer_done_oe       <= 1'b0;
      frame_end_req          <= 2'h0;
    end else begin
      rx_pop        <= 2'h0;
      tx_push       <= 2'h0;
      frame_end_req <= 2'h0;
      if (!dtc_n) begin
        transfer_done_n  <= 1'b1;
        transfer_done_oe <= 1'b0;
      end
      for (int c = 0; c < 2; c++) begin
        if (!dtc_n || (rak_n[c] && tak_n[c] && !fifo_access)) begin
          rx_hold_r[c] <= 1'b0;
          tx_hold_r[c] <= 1'b0;
        end
        case (mode[c])
          DMA_HSA, DMA_HDA: begin
            // One shared request; receive takes precedence over transmit.
            shared_rx_r[c] <= rx_rdy[c];
            rx_or_shared_request_n[c] <= ~((rx_rdy[c] | tx_rdy[c]) & ~rx_hold_r[c]);
            tx_request_n[c] <= 1'b1;
          end
          DMA_FSA, DMA_FDA: begin
            shared_rx_r[c] <= 1'b1;
            rx_or_shared_request_n[c] <= ~(rx_rdy[c] & ~rx_hold_r[c]);
            tx_request_n[c] <= ~(tx_rdy[c] & ~tx_hold_r[c]);
          end
          default: begin
            rx_or_shared_request_n[c] <= 1'b1;
            tx_request_n[c] <= 1'b1;
            shared_rx_r[c] <= 1'b0;
          end
        endcase
        if (mode[c] == DMA_HSA || mode[c] == DMA_FSA) begin
          if (rak_fall[c]) begin
            if (shared_rx_r[c] || mode[c] == DMA_FSA) begin
              rx_pop[c] <= 1'b1;
              if (cs[c].rx_count == 3'h1) rx_hold_r[c] <= 1'b1;
              if (cs[c].head_eom && cs[c].receiver_status[RSR_EOM]) begin
                transfer_done_n  <= 1'b0;
                transfer_done_oe <= 1'b1;
              end
            end else begin
              tx_push[c] <= 1'b1;
              if (cs[c].tx_count == 3'(FIFO_DEPTH - 1)) rx_hold_r[c] <= 1'b1;
            end
          end
          if (mode[c] == DMA_FSA && tak_fall[c]) begin
            tx_push[c] <= 1'b1;
            if (cs[c].tx_count == 3'(FIFO_DEPTH - 1)) tx_hold_r[c] <= 1'b1;
          end
          if ((rak_fall[c] && mode[c] == DMA_HSA && !shared_rx_r[c]) ||
              (tak_fall[c] && mode[c] == DMA_FSA)) begin
            if (!done_in_n && tpr_r[c][TPR_AUTO_EOM]) frame_end_req[c] <= 1'b1;
            if (cs[c].tc_reached) begin
              transfer_done_n  <= 1'b0;
              transfer_done_oe <= 1'b1;
            end
          end
        end
        // Dual-address transfers are ordinary register port cycles.
        if ((mode[c] == DMA_HDA || mode[c] == DMA_FDA || mode[c] == DMA_WAIT ||
             mode[c] == DMA_NONE) && fifo_access && fifo_chan == 1'(c) &&
            wait_ok[c] && !wait_pend_r) begin
          if (fifo_write) tx_push[c] <= 1'b1;
          else rx_pop[c] <= 1'b1;
          if (fifo_write && cs[c].tx_count == 3'(FIFO_DEPTH - 1)) tx_hold_r[c] <= 1'b1;
          if (!fifo_write && cs[c].rx_count == 3'h1) rx_hold_r[c] <= 1'b1;
        end
      end
    end
  end

  // Wait-state handshake: the access stands until a slot or a character exists.
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      wait_ok[c] = (mode[c] != DMA_WAIT) ||
                   (fifo_write ? (cs[c].tx_count != 3'(FIFO_DEPTH))
                               : (cs[c].rx_count != 3'h0));
    end
  end
  assign bus_ack = fifo_access && !wait_pend_r && wait_ok[fifo_chan];
  always_ff @(posedge clock) begin
    if (reset) begin
      transfer_ack_out_n <= 1'b1;
      wait_pend_r        <= 1'b0;
    end else begin
      if (ack_r == ACK_OWN) transfer_ack_out_n <= 1'b0;
      else transfer_ack_out_n <= ~bus_ack;
      wait_pend_r <= fifo_access && (wait_pend_r || bus_ack);
    end
  end

  // Register port.
  always_ff @(posedge clock) begin
    if (reset) begin
      icr_r  <= RST_REG;
      ivr_r  <= RST_REG;
      port_control_reg_a_r <= RST_REG;
      for (int c = 0; c < 2; c++) begin
        ier_r[c]  <= RST_REG;
        counter_control_reg_r[c] <= RST_REG;
        omr_r[c]  <= RST_REG;
        channel_mode_reg_2_r[c] <= RST_REG;
        tpr_r[c]  <= RST_REG;
      end
    end else if (reg_write) begin
      case (reg_addr)
        OFS_ICR:    icr_r     <= reg_wdata;
        OFS_IVR:    ivr_r     <= reg_wdata;
        OFS_PORT_CONTROL_REG_A:   port_control_reg_a_r    <= reg_wdata;
        OFS_IER_A:  ier_r[0]  <= reg_wdata;
        OFS_IER_B:  ier_r[1]  <= reg_wdata;
        OFS_COUNTER_CONTROL_REG_A: counter_control_reg_r[0] <= reg_wdata;
        OFS_COUNTER_CONTROL_REG_B: counter_control_reg_r[1] <= reg_wdata;
        OFS_OMR_A:  omr_r[0]  <= reg_wdata;
        OFS_OMR_B:  omr_r[1]  <= reg_wdata;
        OFS_CHANNEL_MODE_REG_2_A: channel_mode_reg_2_r[0] <= reg_wdata;
        OFS_CHANNEL_MODE_REG_2_B: channel_mode_reg_2_r[1] <= reg_wdata;
        OFS_TPR_A:  tpr_r[0]  <= reg_wdata;
        OFS_TPR_B:  tpr_r[1]  <= reg_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (reset) reg_rdata <= RST_REG;
    else if (reg_read) begin
      case (reg_addr)
        OFS_ICR:    reg_rdata <= icr_r;
        OFS_IVR:    reg_rdata <= ivr_r;
        OFS_MODIFIED_VECTOR_REG:   reg_rdata <= modified_vector_reg_r;
        OFS_GSR:    reg_rdata <= gsr_r;
        OFS_PORT_CONTROL_REG_A:   reg_rdata <= port_control_reg_a_r;
        OFS_IER_A:  reg_rdata <= ier_r[0];
        OFS_IER_B:  reg_rdata <= ier_r[1];
        OFS_COUNTER_CONTROL_REG_A: reg_rdata <= counter_control_reg_r[0];
        OFS_COUNTER_CONTROL_REG_B: reg_rdata <= counter_control_reg_r[1];
        OFS_OMR_A:  reg_rdata <= omr_r[0];
        OFS_OMR_B:  reg_rdata <= omr_r[1];
        OFS_CHANNEL_MODE_REG_2_A: reg_rdata <= channel_mode_reg_2_r[0];
        OFS_CHANNEL_MODE_REG_2_B: reg_rdata <= channel_mode_reg_2_r[1];
        OFS_TPR_A:  reg_rdata <= tpr_r[0];
        OFS_TPR_B:  reg_rdata <= tpr_r[1];
        default:    reg_rdata <= RST_REG;
      endcase
    end else reg_rdata <= RST_REG;
  end

endmodule : schs_host_service

`default_nettype wire

// >>> testbench/schs_host_service_sva.sv
// Checker for the host-service block ports.
`timescale 1ns/1ps
`default_nettype none
module schs_host_service_sva
  import schs_pkg::*;
(
  input wire logic       clock,
  input wire logic       reset,
  input wire logic       interrupt_ack_in_n,
  input wire logic       interrupt_request_out_n,
  input wire logic       transfer_ack_out_n,
  input wire logic       vector_oe,
  input wire logic       osc_or_ack_chain_out,
  input wire logic [1:0] rx_or_shared_request_n,
  input wire logic [1:0] tx_request_n,
  input wire logic [1:0] rx_or_shared_ack_n,
  input wire logic [1:0] tx_ack_n,
  input wire logic       transfer_done_n,
  input wire logic       transfer_done_oe,
  input wire logic       fifo_access,
  input wire logic [1:0] rx_pop
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  sequence s_vec_up; $rose(vector_oe); endsequence
  sequence s_ack_low; !transfer_ack_out_n; endsequence
  property p_vec_then_ack; s_vec_up |=> s_ack_low; endproperty
  a_vec_then_ack: assert property (p_vec_then_ack) else $error("no ack after vector");
  property p_vec_cause; s_vec_up |-> !$past(interrupt_ack_in_n); endproperty
  a_vec_cause: assert property (p_vec_cause) else $error("vector without acknowledge");
  property p_ack_cause;
    $fell(transfer_ack_out_n) |-> vector_oe || fifo_access || rx_or_shared_ack_n != 2'b11
      || tx_ack_n != 2'b11;
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without a cycle");
  property p_chain_excl; !(vector_oe && !osc_or_ack_chain_out); endproperty
  a_chain_excl: assert property (p_chain_excl) else $error("chain and vector together");
  property p_chain_cause; $fell(osc_or_ack_chain_out) |-> !$past(interrupt_ack_in_n); endproperty
  a_chain_cause: assert property (p_chain_cause) else $error("chain without acknowledge");
  property p_chain_end;
    !osc_or_ack_chain_out && interrupt_ack_in_n |-> ##[1:4] osc_or_ack_chain_out;
  endproperty
  a_chain_end: assert property (p_chain_end) else $error("chain not released");
  property p_pop_pulse; rx_pop[0] |=> !rx_pop[0]; endproperty
  a_pop_pulse: assert property (p_pop_pulse) else $error("pop longer than a cycle");
  property p_done_drive; transfer_done_oe |-> !transfer_done_n; endproperty
  a_done_drive: assert property (p_done_drive) else $error("done driven high");
  property p_reset_idle;
    $fell(reset) |-> interrupt_request_out_n && transfer_ack_out_n && !vector_oe
      && rx_or_shared_request_n == 2'b11 && tx_request_n == 2'b11;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("outputs active after reset");
endmodule : schs_host_service_sva

bind schs_host_service schs_host_service_sva u_sva (
  .clock(clock), .reset(reset), .interrupt_ack_in_n(interrupt_ack_in_n),
  .interrupt_request_out_n(interrupt_request_out_n), .transfer_ack_out_n(transfer_ack_out_n),
  .vector_oe(vector_oe), .osc_or_ack_chain_out(osc_or_ack_chain_out),
  .rx_or_shared_request_n(rx_or_shared_request_n), .tx_request_n(tx_request_n),
  .rx_or_shared_ack_n(rx_or_shared_ack_n), .tx_ack_n(tx_ack_n),
  .transfer_done_n(transfer_done_n), .transfer_done_oe(transfer_done_oe),
  .fifo_access(fifo_access), .rx_pop(rx_pop)
);
`default_nettype wire

// >>> testbench/schs_dma_partner.sv
// Model of the DMA controller serving channel A receive requests.
`timescale 1ns/1ps
`default_nettype none
module schs_dma_partner (
  input wire logic       clock,
  input wire logic       reset,
  input wire logic [1:0] rx_or_shared_request_n,
  input wire logic [1:0] rx_pop,
  input wire logic [3:0] lag,
  output logic [1:0]     rx_or_shared_ack_n,
  output logic [1:0]     tx_ack_n,
  output logic           transfer_complete_in_n,
  output logic           transfer_done_in_n
);
  int n;
  initial begin
    rx_or_shared_ack_n = 2'b11;
    tx_ack_n = 2'b11;
    transfer_complete_in_n = 1'b1;
    transfer_done_in_n = 1'b1;
    forever begin
      @(posedge clock);
      if (!reset && rx_or_shared_request_n[0] === 1'b0) begin
        repeat (lag) @(posedge clock);
        rx_or_shared_ack_n <= 2'b10;
        for (n = 0; n < 12; n++) begin
          @(posedge clock);
          #1;
          if (rx_pop[0] === 1'b1) break;
        end
        transfer_complete_in_n <= 1'b0;
        @(posedge clock);
        #1;
        rx_or_shared_ack_n <= 2'b11;
        transfer_complete_in_n <= 1'b1;
        // The gap lets the synchronised acknowledge settle before the next request is seen.
        repeat (4) @(posedge clock);
      end
    end
  end
endmodule : schs_dma_partner
`default_nettype wire

// >>> testbench/schs_host_service_tb.sv
// Self-checking bench for the host-service block.
`timescale 1ns/1ps
`default_nettype none
module schs_host_service_tb
  import schs_pkg::*;
;
  logic clock, reset, reg_write, reg_read, iack_n, irq_n, tack_n, vec_oe, chain_n;
  logic cpl_n, dne_n, done_n, done_oe, fifo_access, fifo_write, fifo_chan, seen_done;
  logic [3:0] reg_addr, lag, interrupt_enable_reg;
  logic [7:0] reg_wdata, reg_rdata, vec, d, base_vector_reg, ics, rs, trs;
  logic [1:0] rq_n, tq_n, rak_n, tak_n, rx_pop, tx_push, frame_end_req;
  logic [63:0] r64;
  logic mie, zc;
  schs_chan_stat_t stat_a, stat_b;
  int err_total, comparisons, cycles, pops, pushes, i, n;

  schs_host_service uut (.clock(clock), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .chan_stat_a(stat_a), .chan_stat_b(stat_b), .interrupt_ack_in_n(iack_n),
    .interrupt_request_out_n(irq_n), .transfer_ack_out_n(tack_n), .vector_out(vec),
    .vector_oe(vec_oe), .osc_or_ack_chain_out(chain_n), .rx_or_shared_request_n(rq_n),
    .tx_request_n(tq_n), .rx_or_shared_ack_n(rak_n), .tx_ack_n(tak_n),
    .transfer_complete_in_n(cpl_n), .transfer_done_in_n(dne_n), .transfer_done_n(done_n),
    .transfer_done_oe(done_oe), .fifo_access(fifo_access), .fifo_write(fifo_write),
    .fifo_chan(fifo_chan), .rx_pop(rx_pop), .tx_push(tx_push), .frame_end_req(frame_end_req));
  schs_dma_partner u_dma (.clock(clock), .reset(reset), .rx_or_shared_request_n(rq_n),
    .rx_pop(rx_pop), .lag(lag), .rx_or_shared_ack_n(rak_n), .tx_ack_n(tak_n),
    .transfer_complete_in_n(cpl_n), .transfer_done_in_n(dne_n));

  always #5 clock = ~clock;
  // The receive FIFO level follows the pops, standing in for the channel engine.
  always @(posedge clock) begin
    cycles++;
    if (rx_pop[0] === 1'b1) begin
      pops++;
      stat_a.rx_count <= stat_a.rx_count - 3'h1;
    end
    if (tx_push[0] === 1'b1) pushes++;
    if (done_oe === 1'b1) seen_done = 1'b1;
    if (cycles == 20000) begin
      err_total++;
      tally_and_finish();
    end
  end

  function automatic logic exp_irq(logic [7:0] c, logic [7:0] s, logic [7:0] t, logic [3:0] e,
                                   logic m, logic z);
    exp_irq = m && ((e[IER_EXT] && (c[5:4] != 2'h0 || (c[6] && z)))
      || (e[IER_ERR] && (s != 8'h00 || t[7:3] != 5'h00)));
  endfunction : exp_irq

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    v = reg_rdata;
  endtask : rd

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : tally_and_finish

  initial begin
    clock = 0; reset = 1; reg_addr = 0; reg_wdata = 0; reg_write = 0; reg_read = 0;
    stat_a = '0; stat_a.tx_count = 3'h4; stat_b = '0; iack_n = 1; lag = 0; seen_done = 0;
    fifo_access = 0; fifo_write = 0; fifo_chan = 0; err_total = 0; comparisons = 0;
    cycles = 0; pops = 0; pushes = 0;
    n = $urandom(75764);
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    repeat (3) @(posedge clock);
    check("irq_n", irq_n, 1);
    rd(4'hf, d);
    check("unmapped", d, 8'h00);
    $display("test reset done");
    wr(OFS_IER_B, 8'h0f);
    for (i = 0; i < 24; i++) begin
      ics = $urandom & (i[0] ? 8'hff : 8'h8f);
      rs = $urandom & (i[1] ? 8'hff : 8'h00);
      trs = $urandom & (i[2] ? 8'hff : 8'h07);
      interrupt_enable_reg = $urandom; zc = $urandom; mie = $urandom; r64 = {$urandom, $urandom};
      wr(OFS_IER_A, {4'h0, interrupt_enable_reg});
      wr(OFS_COUNTER_CONTROL_REG_A, {zc, 7'h00});
      wr(OFS_ICR, {6'h00, mie, 1'b0});
      stat_a.input_counter_status <= ics;
      stat_a.receiver_status <= rs;
      stat_a.tx_rx_status <= trs;
      stat_b <= r64[32:0];
      repeat (4) @(posedge clock);
      check("irq_n", irq_n, {7'h0, ~exp_irq(ics, rs, trs, interrupt_enable_reg, mie, zc)});
    end
    $display("test interrupt merge done");
    stat_b <= '0; stat_a.input_counter_status <= 0; stat_a.tx_rx_status <= 0;
    stat_a.receiver_status <= 8'h04; base_vector_reg = $urandom;
    wr(OFS_IER_A, 8'h02);
    wr(OFS_IVR, base_vector_reg);
    for (i = 0; i < 2; i++) begin
      wr(OFS_ICR, 8'h12 | (i << ICR_VMOD));
      rd(OFS_ICR, d);
      check("icr", d, 8'h12 | (i << ICR_VMOD));
      iack_n <= 1'b0;
      for (n = 0; n < 12 && tack_n !== 1'b0; n++) @(posedge clock);
      check("tack_n", tack_n, 0);
      check("vec_oe", vec_oe, 1);
      check("vector", vec, i ? {base_vector_reg[7:3], 3'h0} : base_vector_reg);
      iack_n <= 1'b1;
      repeat (6) @(posedge clock);
      check("tack_n", tack_n, 1);
    end
    $display("test vector done");
    stat_a.receiver_status <= 8'h00;
    for (i = 1; i >= 0; i--) begin
      wr(OFS_PORT_CONTROL_REG_A, i ? 8'h80 : 8'h00);
      iack_n <= 1'b0;
      repeat (8) @(posedge clock);
      check("chain_n", chain_n, {7'h0, i == 0});
      check("tack_n", tack_n, 1);
      iack_n <= 1'b1;
      repeat (6) @(posedge clock);
    end
    $display("test chain done");
    wr(OFS_CHANNEL_MODE_REG_2_A, {2'h0, DMA_FSA, 3'h0});
    for (i = 0; i < 3; i++) begin
      wr(OFS_OMR_A, i == 2 ? 8'h08 : 8'h00);
      pops = 0;
      lag <= i * 4;
      stat_a.head_eom <= (i == 1);
      stat_a.receiver_status <= {i == 1, 7'h00};
      stat_a.rx_count <= 3'h3;
      repeat (90) @(posedge clock);
      check("pops", pops, i == 2 ? 0 : 3);
      check("rq_n", rq_n[0], 1);
      stat_a.rx_count <= 3'h0;
      repeat (60) @(posedge clock);
    end
    check("seen_done", seen_done, 1);
    $display("test dma done");
    wr(OFS_CHANNEL_MODE_REG_2_A, {2'h0, DMA_WAIT, 3'h0});
    for (i = 0; i < 2; i++) begin
      pops = 0;
      pushes = 0;
      fifo_write <= i;
      fifo_access <= 1'b1;
      repeat (6) @(posedge clock);
      check("tack_n", tack_n, 1);
      if (i) stat_a.tx_count <= 3'h3;
      else stat_a.rx_count <= 3'h1;
      for (n = 0; n < 12 && tack_n !== 1'b0; n++) @(posedge clock);
      check("tack_n", tack_n, 0);
      fifo_access <= 1'b0;
      repeat (6) @(posedge clock);
      check("xfers", i ? pushes : pops, 1);
    end
    $display("test wait mode done");
    tally_and_finish();
  end
endmodule : schs_host_service_tb
`default_nettype wire
